// ### hw/mtp_pkg.sv
// Notes on behaviour
// - Programming needs reset high, latch low, fetch high.
// - Address from ports 2/1, data on port 0.
// - Read mode drives addressed code or security byte.
// - Locked device reads give invalid data.
// - Output enable high keeps data bus released.
// - Program voltage, enable low, output high writes byte.
// - Program verify returns stored byte.
// - Programming clears bits; erase sets everything to one.
// - Erase needs mode one, erase voltage, A0 zero, FFh.
// - Erase verify reads bytes for all ones.
// - Both enables high inhibit program and erase.
// - Identification read gives maker or device code by A0.
// - Security and identification only in programming mode.
// - Security register sits at top address.
// - Programmed security bits stay zero until erase.
// - Lock flag zero refuses memory and special registers.
// - Table-read inhibit restricts external code table reads.
// - Non-FFh seed scrambles read and verify data.
// - Seeds erase to FFh; scrambling sticks until erase.
// - Seeds program like code at fixed addresses.
// - Seed gate cleared blocks seed access.
package mtp_pkg;

  // ---------------------------------------------------------------
  // Address map and field layout.
  // ---------------------------------------------------------------
  localparam logic [15:0] MTP_SEC_ADDR = 16'hFFFF; // Security register address.
  localparam logic [15:0] MTP_SEED0_ADDR = 16'hFF7F; // First scramble seed.
  localparam logic [15:0] MTP_SEED1_ADDR = 16'hFF3F; // Second scramble seed.
  localparam int MTP_LOCK_BIT = 0; // Lock flag position.
  localparam int MTP_TRI_BIT = 1; // Table-read inhibit position.
  localparam int MTP_SEED_GATE_BIT = 2; // Seed gate position.
  localparam logic [7:0] MTP_ERASED = 8'hFF; // Erased byte value.
  localparam logic [7:0] MTP_LOCKED_DATA = 8'hFF; // Value shown when access is refused.
  localparam logic [7:0] MTP_LFSR_INIT = 8'h01; // Keystream start, nonzero.

  // Levels of the programming voltage pin.
  typedef enum logic [1:0] {
    MTP_VPP_LOGIC,
    MTP_VPP_PROG,
    MTP_VPP_ERASE,
    MTP_VPP_LOW
  } mtp_vpp_t;

  // Decoded operation.
  typedef enum logic [3:0] {
    MTP_OP_IDLE,
    MTP_OP_READ,
    MTP_OP_DISABLE,
    MTP_OP_PROGRAM,
    MTP_OP_PVERIFY,
    MTP_OP_ERASE,
    MTP_OP_EVERIFY,
    MTP_OP_INHIBIT,
    MTP_OP_ID
  } mtp_op_t;

endpackage : mtp_pkg

// ### hw/mtp_decode.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Operation decoder for the programming pins.
// ---------------------------------------------------------------
module mtp_decode (
  input wire logic reset_pin,
  input wire logic addr_latch,
  input wire logic program_fetch_strobe,
  input wire logic mode_pin_one,
  input wire logic mode_pin_two,
  input wire logic mode_pin_three,
  input wire logic mode_pin_four,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire mtp_pkg::mtp_vpp_t vpp,
  output mtp_pkg::mtp_op_t op
);
  import mtp_pkg::*;

  // Combinational truth table; outside programming mode the result is idle, anything unlisted inside it is output disable.
  always_comb begin
    op = MTP_OP_IDLE;
    if (reset_pin && !addr_latch && program_fetch_strobe) begin
      op = MTP_OP_DISABLE;
      if (!mode_pin_two && !mode_pin_three && !mode_pin_four) begin
        unique case ({mode_pin_one, chip_enable_n, output_enable_n})
          3'b000: begin
            if (vpp == MTP_VPP_LOGIC) op = MTP_OP_READ;
          end
          3'b100: begin
            if (vpp == MTP_VPP_LOGIC) op = MTP_OP_ID;
          end
          3'b001: begin
            if (vpp == MTP_VPP_PROG) op = MTP_OP_PROGRAM;
          end
          3'b010: begin
            if (vpp == MTP_VPP_PROG) op = MTP_OP_PVERIFY;
          end
          3'b101: begin
            if (vpp == MTP_VPP_ERASE) op = MTP_OP_ERASE;
          end
          3'b110: begin
            if (vpp == MTP_VPP_ERASE) op = MTP_OP_EVERIFY;
          end
          3'b011, 3'b111: begin
            if (vpp == MTP_VPP_PROG || vpp == MTP_VPP_ERASE) op = MTP_OP_INHIBIT;
          end
          default: op = MTP_OP_DISABLE;
        endcase
      end
    end
  end

endmodule : mtp_decode

// ### hw/mtp_prog.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Programming-mode access to the code memory and security bytes.
// ---------------------------------------------------------------
module mtp_prog #(
  parameter int ADDR_W = 15, // Code memory address width (32 KB).
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value.
  parameter logic [7:0] DEVICE_ID = 8'hA5 // Arbitrary value.
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_pin,
  input wire logic addr_latch,
  input wire logic program_fetch_strobe,
  input wire logic mode_pin_one,
  input wire logic mode_pin_two,
  input wire logic mode_pin_three,
  input wire logic mode_pin_four,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic [1:0] vpp_level,
  input wire logic [15:0] prog_addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic table_read_from_external,
  input wire logic [15:0] table_read_addr,
  output logic table_read_internal_ok,
  output logic lock_flag,
  output logic table_read_inhibit,
  output logic scramble_seed_gate,
  output logic scramble_active
);
  import mtp_pkg::*;

  localparam int DEPTH = 1 << ADDR_W; // Code memory depth.

  // ---------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------
  // Two-stage synchronisers, decoded operation, stored bytes and output.
  typedef struct packed {
    logic [1:0] rp;
    logic [1:0] al;
    logic [1:0] pf;
    logic [3:0] m1;
    logic [3:0] m2;
    logic [3:0] m3;
    logic [3:0] m4;
    logic [1:0] ce;
    logic [1:0] oe;
    logic [3:0] vp;
    logic [31:0] ad;
    logic [15:0] dt;
    mtp_op_t prev_op;
    logic [15:0] last_addr; // Address of the previous cycle, for keystream stepping.
    logic [7:0] sec;
    logic [7:0] seed0;
    logic [7:0] seed1;
    logic [7:0] lfsr;
    logic [7:0] dout;
    logic doe;
  } mtp_state_t;

  mtp_state_t s; // Registered state.
  mtp_state_t next_s; // Next state.
  logic [7:0] mem [DEPTH]; // Code memory cells.
  mtp_op_t op; // Current decoded operation.
  logic [15:0] addr; // Synchronised address.
  logic [7:0] din; // Synchronised data.
  logic [ADDR_W-1:0] cidx; // Code array index.
  logic in_code; // Address hits the code array.
  logic mem_we; // Code byte write strobe.
  logic mem_erase; // Whole-array erase strobe.
  logic [7:0] mem_rd; // Code byte at the current address.
  logic [7:0] mem_wr; // New value for the code byte.
  logic seeds_on; // Scrambling enabled by a seed.

  assign addr = s.ad[31:16];
  assign din = s.dt[15:8];
  assign cidx = addr[ADDR_W-1:0];
  assign in_code = (addr >> ADDR_W) == 16'h0000;
  assign mem_rd = mem[cidx];
  assign mem_wr = mem_rd & din;
  assign seeds_on = (s.seed0 != MTP_ERASED) || (s.seed1 != MTP_ERASED);

  // Four-level pin decode of the already-synchronised level.
  function automatic mtp_vpp_t vpp_of(input logic [1:0] v);
    unique case (v)
      2'd1: vpp_of = MTP_VPP_LOGIC;
      2'd2: vpp_of = MTP_VPP_PROG;
      2'd3: vpp_of = MTP_VPP_ERASE;
      default: vpp_of = MTP_VPP_LOW;
    endcase
  endfunction : vpp_of

  // Decode works only on second-stage synchroniser outputs.
  mtp_decode u_decode (
    .reset_pin(s.rp[1]),
    .addr_latch(s.al[1]),
    .program_fetch_strobe(s.pf[1]),
    .mode_pin_one(s.m1[1]),
    .mode_pin_two(s.m2[1]),
    .mode_pin_three(s.m3[1]),
    .mode_pin_four(s.m4[1]),
    .chip_enable_n(s.ce[1]),
    .output_enable_n(s.oe[1]),
    .vpp(vpp_of(s.vp[3:2])),
    .op(op)
  );

  // ---------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------
  // Protection bits gate every access except erase; writes fire on entry to an operation.
  always_comb begin
    logic fresh;
    logic seed_hit;
    logic [7:0] raw;
    logic scr;
    fresh = 1'b0;
    seed_hit = 1'b0;
    raw = 8'h00;
    scr = 1'b0;
    next_s = s;
    next_s.rp = {s.rp[0], reset_pin};
    next_s.al = {s.al[0], addr_latch};
    next_s.pf = {s.pf[0], program_fetch_strobe};
    next_s.m1 = {2'b00, s.m1[0], mode_pin_one};
    next_s.m2 = {2'b00, s.m2[0], mode_pin_two};
    next_s.m3 = {2'b00, s.m3[0], mode_pin_three};
    next_s.m4 = {2'b00, s.m4[0], mode_pin_four};
    next_s.ce = {s.ce[0], chip_enable_n};
    next_s.oe = {s.oe[0], output_enable_n};
    next_s.vp = {s.vp[1:0], vpp_level};
    next_s.ad = {s.ad[15:0], prog_addr};
    next_s.dt = {s.dt[7:0], data_in};
    next_s.prev_op = op;
    mem_we = 1'b0;
    mem_erase = 1'b0;
    fresh = (op != s.prev_op);
    seed_hit = (addr == MTP_SEED0_ADDR) || (addr == MTP_SEED1_ADDR);
    // Program: one write per entry, only clearing bits.
    if (op == MTP_OP_PROGRAM && fresh && s.sec[MTP_LOCK_BIT]) begin
      if (addr == MTP_SEC_ADDR) begin
        next_s.sec = s.sec & din;
      end else if (seed_hit) begin
        if (s.sec[MTP_SEED_GATE_BIT]) begin
          if (addr == MTP_SEED0_ADDR) next_s.seed0 = s.seed0 & din;
          else next_s.seed1 = s.seed1 & din;
        end
      end else if (in_code) begin
        mem_we = 1'b1;
      end
    end
    // Erase: A0 low and all-ones data required.
    if (op == MTP_OP_ERASE && fresh && !addr[0] && din == MTP_ERASED) begin
      mem_erase = 1'b1;
      next_s.sec = MTP_ERASED;
      next_s.seed0 = MTP_ERASED;
      next_s.seed1 = MTP_ERASED;
    end
    // Read data source.
    if (addr == MTP_SEC_ADDR) raw = s.sec;
    else if (seed_hit) raw = s.sec[MTP_SEED_GATE_BIT] ? (addr == MTP_SEED0_ADDR ?
      s.seed0 : s.seed1) : MTP_LOCKED_DATA;
    else if (in_code) begin
      raw = mem_rd;
      scr = seeds_on;
    end else raw = MTP_ERASED;
    // Keystream steps on each new address in every operation; idle restarts it.
    // Only the second synchroniser stage is compared, never the first.
    if (addr != s.last_addr) begin
      next_s.lfsr = {s.lfsr[6:0], s.lfsr[7] ^ s.lfsr[5] ^ s.lfsr[4] ^ s.lfsr[3]};
    end
    next_s.last_addr = addr;
    next_s.doe = 1'b0;
    next_s.dout = 8'h00;
    unique case (op)
      MTP_OP_READ, MTP_OP_PVERIFY, MTP_OP_EVERIFY: begin
        next_s.doe = 1'b1;
        if (!s.sec[MTP_LOCK_BIT]) next_s.dout = MTP_LOCKED_DATA;
        else next_s.dout = scr ? 8'(raw + (s.lfsr ^ s.seed0 ^ s.seed1)) : raw;
      end
      MTP_OP_ID: begin
        next_s.doe = 1'b1;
        if (!s.sec[MTP_LOCK_BIT]) next_s.dout = MTP_LOCKED_DATA;
        else next_s.dout = addr[0] ? DEVICE_ID : MAKER_ID;
      end
      default: begin
        next_s.doe = 1'b0;
      end
    endcase
    if (op == MTP_OP_IDLE) next_s.lfsr = MTP_LFSR_INIT;
  end

  // ---------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------
  // State register; stored bytes model nonvolatile cells and start erased.
  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
      s.prev_op <= MTP_OP_IDLE;
      s.sec <= MTP_ERASED;
      s.seed0 <= MTP_ERASED;
      s.seed1 <= MTP_ERASED;
      s.lfsr <= MTP_LFSR_INIT;
    end else begin
      s <= next_s;
    end
  end

  // Code array write and erase.
  always_ff @(posedge mclk) begin
    if (mem_erase) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= MTP_ERASED;
    end else if (mem_we) begin
      mem[cidx] <= mem_wr;
    end
  end

  // ---------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------
  assign data_out = s.dout;
  assign data_oe = s.doe;
  assign lock_flag = s.sec[MTP_LOCK_BIT];
  assign table_read_inhibit = s.sec[MTP_TRI_BIT];
  assign scramble_seed_gate = s.sec[MTP_SEED_GATE_BIT];
  assign scramble_active = seeds_on;
  // External code table reads may not reach internal space when inhibited.
  assign table_read_internal_ok = s.sec[MTP_TRI_BIT] || !table_read_from_external ||
    ((table_read_addr >> ADDR_W) != 16'h0000);

endmodule : mtp_prog

// ### sim/mtp_prog_monitor.sv
`timescale 1ns/1ps
// ----
// Port checker for the programming interface.
// ----
module mtp_prog_monitor #(
  parameter int ADDR_W = 15,
  parameter logic [7:0] MAKER_ID = 8'h5A,
  parameter logic [7:0] DEVICE_ID = 8'hA5
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reset_pin,
  input wire logic addr_latch,
  input wire logic program_fetch_strobe,
  input wire logic mode_pin_one,
  input wire logic mode_pin_two,
  input wire logic mode_pin_three,
  input wire logic mode_pin_four,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic [1:0] vpp_level,
  input wire logic [15:0] prog_addr,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic table_read_from_external,
  input wire logic [15:0] table_read_addr,
  input wire logic table_read_internal_ok,
  input wire logic lock_flag,
  input wire logic table_read_inhibit,
  input wire logic scramble_seed_gate,
  input wire logic scramble_active
);
  import mtp_pkg::*;
  logic pm; // All qualifiers of programming mode are met.
  logic idm; // Identification read pins, device unlocked.
  logic rdm; // Plain read pins.
  logic [2:0] er_cnt; // Recent sight of erase voltage.
  assign pm = reset_pin & ~addr_latch & program_fetch_strobe & ~mode_pin_two
    & ~mode_pin_three & ~mode_pin_four;
  assign idm = pm & mode_pin_one & ~chip_enable_n & ~output_enable_n
    & (vpp_level == 2'h1) & lock_flag;
  assign rdm = pm & ~mode_pin_one & ~chip_enable_n & ~output_enable_n & (vpp_level == 2'h1);
  // Keeps a short window open after erase voltage, since erase is the only way up.
  always_ff @(posedge mclk) begin
    if (rst) er_cnt <= 3'h0;
    else if (vpp_level == 2'h3) er_cnt <= 3'h7;
    else if (er_cnt != 3'h0) er_cnt <= er_cnt - 3'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_oe_release: assert property ((output_enable_n && vpp_level == 2'h1) [*4] |-> !data_oe)
    else $error("Bus driven with output off");
  chk_mode_off: assert property ((mode_pin_two || mode_pin_three || mode_pin_four) [*4] |-> !data_oe)
    else $error("Bus driven with stray mode pin");
  chk_reset_off: assert property ((!reset_pin) [*4] |-> !data_oe)
    else $error("Bus driven outside programming mode");
  chk_maker_id: assert property ((idm && !prog_addr[0]) [*4] |-> data_out == MAKER_ID)
    else $error("Wrong maker code");
  chk_device_id: assert property ((idm && prog_addr[0]) [*4] |-> data_out == DEVICE_ID)
    else $error("Wrong device code");
  chk_lock_read: assert property ((rdm && !lock_flag) [*4] |-> data_out == MTP_LOCKED_DATA)
    else $error("Locked read shows contents");
  chk_sec_sticky: assert property ($rose(lock_flag) || $rose(table_read_inhibit)
    || $rose(scramble_seed_gate) |-> er_cnt != 3'h0) else $error("Security bit rose");
  chk_scram_hold: assert property ($fell(scramble_active) |-> er_cnt != 3'h0)
    else $error("Scrambling dropped without erase");
  chk_table_ext: assert property (table_read_from_external && !table_read_inhibit
    && ((table_read_addr >> ADDR_W) == 16'h0000) |-> !table_read_internal_ok)
    else $error("External table read reached code");
  chk_drive_cause: assert property ($rose(data_oe) |-> $past(output_enable_n, 3) == 1'b0)
    else $error("Bus driven without output enable");
  cov_id: cover property (idm [*4]);
  cov_lock: cover property ($fell(lock_flag));
  cov_scram: cover property ($rose(scramble_active));
endmodule : mtp_prog_monitor

bind mtp_prog mtp_prog_monitor #(.ADDR_W(ADDR_W), .MAKER_ID(MAKER_ID), .DEVICE_ID(DEVICE_ID))
  mtp_prog_monitor_inst (.*);

// ### sim/mtp_programmer.sv
`timescale 1ns/1ps
// ----
// Programmer model: sets pin levels for the requested operation.
// ----
module mtp_programmer (
  input wire logic mclk,
  input wire mtp_pkg::mtp_op_t op,
  input wire logic stray,
  input wire logic [7:0] wdata,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output logic reset_pin,
  output logic addr_latch,
  output logic program_fetch_strobe,
  output logic mode_pin_one,
  output logic mode_pin_two,
  output logic mode_pin_three,
  output logic mode_pin_four,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic [1:0] vpp_level,
  output logic [7:0] data_in
);
  import mtp_pkg::*;
  logic [7:0] last; // Last bus level, inverted when nobody drives.
  // Idle drops the reset pin; every other op keeps programming mode.
  always_comb begin
    reset_pin = (op != MTP_OP_IDLE);
    addr_latch = 1'b0;
    program_fetch_strobe = 1'b1;
    mode_pin_two = stray;
    mode_pin_three = 1'b0;
    mode_pin_four = 1'b0;
    mode_pin_one = op inside {MTP_OP_ERASE, MTP_OP_EVERIFY, MTP_OP_ID};
    chip_enable_n = op inside {MTP_OP_PVERIFY, MTP_OP_EVERIFY, MTP_OP_INHIBIT};
    output_enable_n = !(op inside {MTP_OP_READ, MTP_OP_PVERIFY, MTP_OP_EVERIFY, MTP_OP_ID});
    case (op)
      MTP_OP_PROGRAM, MTP_OP_PVERIFY, MTP_OP_INHIBIT: vpp_level = 2'h2;
      MTP_OP_ERASE, MTP_OP_EVERIFY: vpp_level = 2'h3;
      default: vpp_level = 2'h1;
    endcase
  end
  // Bus level: device, else programmer while output is off, else floating.
  assign data_in = data_oe ? data_out : (output_enable_n ? wdata : ~last);
  always_ff @(posedge mclk) last <= data_in;
endmodule : mtp_programmer

// ### sim/tb_mtp_prog.sv
`timescale 1ns/1ps
// ----
// Self-checking bench for the programming interface.
// ----
module tb_mtp_prog;
  import mtp_pkg::*;
  localparam logic [7:0] MK = 8'h3C; // Arbitrary maker code.
  localparam logic [7:0] DV = 8'hC3; // Arbitrary device code.
  logic mclk = 1'b0;
  logic rst = 1'b1;
  mtp_op_t op = MTP_OP_DISABLE;
  logic stray = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [15:0] prog_addr = 16'h0000;
  logic table_read_from_external = 1'b0;
  logic [15:0] table_read_addr = 16'h0000;
  logic reset_pin, addr_latch, program_fetch_strobe, chip_enable_n, output_enable_n;
  logic mode_pin_one, mode_pin_two, mode_pin_three, mode_pin_four;
  logic [1:0] vpp_level;
  logic [7:0] data_in, data_out, flags;
  logic data_oe, table_read_internal_ok, lock_flag, table_read_inhibit;
  logic scramble_seed_gate, scramble_active;
  logic [15:0] lf = 16'd3431;
  logic [7:0] mem [8];
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int i;
  assign flags = {3'h0, scramble_active, scramble_seed_gate, table_read_inhibit, lock_flag,
    data_oe};
  always #4 mclk = ~mclk;
  mtp_prog #(.ADDR_W(6), .MAKER_ID(MK), .DEVICE_ID(DV)) mtp_prog_inst (.*);
  mtp_programmer mtp_programmer_inst (.*);
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  // Address and data settle before the op changes, then the answer settles.
  task automatic do_op(input mtp_op_t o, input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    prog_addr <= a;
    wdata <= d;
    repeat (4) @(posedge mclk);
    op <= o;
    repeat (6) @(posedge mclk);
    #1;
  endtask : do_op
  // The bus is released first so that the programmer, not the device, drives the data.
  task automatic wr(input mtp_op_t o, input logic [15:0] a, input logic [7:0] d);
    do_op(MTP_OP_DISABLE, a, d);
    do_op(o, a, d);
    do_op(MTP_OP_DISABLE, a, d);
  endtask : wr
  task automatic rd(input mtp_op_t o, input logic [15:0] a, input logic [7:0] e);
    do_op(o, a, 8'h00);
    chk(data_out, e);
  endtask : rd
  task automatic note(input string s);
    $display("Test %s done", s);
  endtask : note
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  // Cuts a hang short.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(flags, 8'h0E);
    wr(MTP_OP_ERASE, 16'h0000, 8'hFF);
    for (i = 0; i < 8; i++) rd(MTP_OP_EVERIFY, 16'(i * 9), 8'hFF);
    rd(MTP_OP_READ, MTP_SEC_ADDR, 8'hFF);
    note("erase");
    for (i = 0; i < 8; i++) begin
      lf = lfsr_next(lf);
      mem[i] = lf[7:0];
      wr(MTP_OP_PROGRAM, 16'(i * 9), mem[i]);
      rd(MTP_OP_PVERIFY, 16'(i * 9), mem[i]);
    end
    for (i = 0; i < 8; i++) begin
      lf = lfsr_next(lf);
      mem[i] &= lf[7:0];
      wr(MTP_OP_PROGRAM, 16'(i * 9), lf[7:0]);
      rd(MTP_OP_READ, 16'(i * 9), mem[i]);
    end
    note("program");
    wr(MTP_OP_INHIBIT, 16'h0000, 8'h00);
    rd(MTP_OP_READ, 16'h0000, mem[0]);
    @(posedge mclk);
    stray <= 1'b1;
    wr(MTP_OP_PROGRAM, 16'h0009, 8'h00);
    do_op(MTP_OP_READ, 16'h0009, 8'h00);
    chk(flags, 8'h0E);
    @(posedge mclk);
    stray <= 1'b0;
    rd(MTP_OP_READ, 16'h0009, mem[1]);
    do_op(MTP_OP_DISABLE, 16'h0009, 8'h00);
    chk(flags, 8'h0E);
    do_op(MTP_OP_IDLE, 16'h0009, 8'h00);
    chk(flags, 8'h0E);
    rd(MTP_OP_ID, 16'h0000, MK);
    rd(MTP_OP_ID, 16'h0001, DV);
    note("modes");
    wr(MTP_OP_PROGRAM, MTP_SEC_ADDR, 8'hFD);
    wr(MTP_OP_PROGRAM, MTP_SEC_ADDR, 8'hFF);
    chk(flags, 8'h0A);
    @(posedge mclk);
    table_read_from_external <= 1'b1;
    table_read_addr <= {10'h000, lf[5:0]};
    @(posedge mclk);
    #1;
    chk({7'h00, table_read_internal_ok}, 8'h00);
    @(posedge mclk);
    table_read_from_external <= 1'b0;
    @(posedge mclk);
    #1;
    chk({7'h00, table_read_internal_ok}, 8'h01);
    wr(MTP_OP_PROGRAM, MTP_SEED0_ADDR, 8'h12);
    chk(flags, 8'h1A);
    wr(MTP_OP_PROGRAM, MTP_SEC_ADDR, 8'hF9);
    rd(MTP_OP_READ, MTP_SEED0_ADDR, 8'hFF);
    wr(MTP_OP_PROGRAM, MTP_SEC_ADDR, 8'hF8);
    chk(flags, 8'h10);
    rd(MTP_OP_READ, 16'h0000, MTP_LOCKED_DATA);
    rd(MTP_OP_ID, 16'h0000, MTP_LOCKED_DATA);
    wr(MTP_OP_ERASE, 16'h0000, 8'hFF);
    chk(flags, 8'h0E);
    rd(MTP_OP_READ, 16'h003F, 8'hFF);
    note("security");
    complete_run();
  end
endmodule : tb_mtp_prog
